// File: bench/tb_tpc_timer_ctl.sv
// self-checking bench for the timer, option byte and programming control block
`include "tpc_regs.svh"
module tb_tpc_timer_ctl;
  timeunit 1ns;
  timeprecision 1ps;
  // bus, pins and observed outputs
  logic clk_sys, rstn, wb_cyc_i, wb_stb_i, wb_we_i;
  logic [13:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic wb_ack_o, timer_pin, vpp_high, ext_pin_enable, timer_irq;
  // mismatch and comparison counts
  int failures = 0;
  int compares = 0;
  int t;

  tpc_timer_ctl i_tpc_timer_ctl (
    .clk_sys(clk_sys), .rstn(rstn),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .timer_pin(timer_pin), .vpp_high(vpp_high),
    .ext_pin_enable(ext_pin_enable), .timer_irq(timer_irq)
  );

  // 40 MHz system clock
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  // compare one byte, four-state exact
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      $display("unexpected %s expected %h seen %h", what, exp, got);
      failures++;
    end
  endtask

  // wait a number of rising edges
  task automatic idle(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  // one classic cycle, held until ack is sampled high at an edge
  task automatic xfer(input logic [11:0] idx, input logic we, input logic [7:0] wd, output logic [7:0] rdat);
    int n;
    n = 0;
    @(posedge clk_sys);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= {idx, 2'b00};
    wb_dat_i <= {24'h00_0000, wd};
    do begin
      @(posedge clk_sys);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 40);
    rdat = wb_dat_o[7:0];
    check("bus ack", 8'h01, {7'h00, wb_ack_o});
    // release only after the answering edge
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask

  // register write
  task automatic wr(input logic [11:0] idx, input logic [7:0] wd);
    logic [7:0] dummy;
    xfer(idx, 1'b1, wd, dummy);
  endtask

  // register read and compare
  task automatic rd_chk(input string what, input logic [11:0] idx, input logic [7:0] exp);
    logic [7:0] got;
    xfer(idx, 1'b0, 8'h00, got);
    check(what, exp, got);
  endtask

  // pin pulses of five clocks high and five low, slower than fosc/8
  task automatic pulses(input int n);
    repeat (n) begin
      timer_pin <= 1'b1;
      idle(5);
      timer_pin <= 1'b0;
      idle(5);
    end
  endtask

  // load the counter, apply pin pulses, read the count back
  task automatic ext_count(input string what, input logic [7:0] load, input int n, input logic [7:0] exp);
    wr(`TPC_IDX_TDR, load);
    pulses(n);
    idle(6);
    rd_chk(what, `TPC_IDX_TDR, exp);
  endtask

  // reset held for six clocks, then startup settles
  task automatic do_reset();
    rstn <= 1'b0;
    idle(6);
    rstn <= 1'b1;
    idle(4);
  endtask

  task automatic end_test(input string name);
    $display("test %s done", name);
  endtask

  // counts, verdict and end of run
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // watchdog: the tests need well under half this span
  initial begin
    idle(20000);
    failures++;
    report_and_stop();
  end

  initial begin
    rstn = 1'b0;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 14'h0000;
    wb_sel_i = 4'h1;
    wb_dat_i = 32'h0000_0000;
    timer_pin = 1'b0;
    vpp_high = 1'b0;
    do_reset();
    // erased option byte gives software mode with zero initial fields
    rd_chk("option byte", `TPC_IDX_OPT, 8'h00);
    rd_chk("timer control", `TPC_IDX_TCR, 8'h00);
    rd_chk("programming control", `TPC_IDX_PCR, 8'hFF);
    rd_chk("unmapped", 12'h010, 8'h00);
    wr(`TPC_IDX_OPT, 8'hFF);
    rd_chk("option read only", `TPC_IDX_OPT, 8'h00);
    // flag cannot be set by software, clear bit reads zero
    wr(`TPC_IDX_TCR, 8'hFF);
    rd_chk("control write", `TPC_IDX_TCR, 8'h77);
    check("pin enable", 8'h01, {7'h00, ext_pin_enable});
    end_test("reset and access");
    // every select code, internal source, period from load to request
    for (int n = 0; n < 8; n++) begin
      wr(`TPC_IDX_TCR, 8'h08 | 8'(n));
      wr(`TPC_IDX_TDR, 8'h01);
      t = 0;
      while (timer_irq !== 1'b1 && t < 1000) begin
        idle(1);
        t++;
      end
      compares++;
      if (t < (4 << n) - 8 || t > (4 << n) + 6) begin
        $display("unexpected tap period expected %0d seen %0d", 4 << n, t);
        failures++;
      end
      rd_chk("flag set", `TPC_IDX_TCR, 8'h80 | 8'(n));
    end
    end_test("prescaler taps");
    // mask hides the request, flag stays until written zero
    wr(`TPC_IDX_TCR, 8'hC7);
    idle(2);
    check("masked irq", 8'h00, {7'h00, timer_irq});
    rd_chk("flag kept", `TPC_IDX_TCR, 8'hC7);
    wr(`TPC_IDX_TCR, 8'h87);
    idle(2);
    check("unmasked irq", 8'h01, {7'h00, timer_irq});
    wr(`TPC_IDX_TCR, 8'h07);
    idle(2);
    check("cleared irq", 8'h00, {7'h00, timer_irq});
    rd_chk("flag cleared", `TPC_IDX_TCR, 8'h07);
    end_test("flag and mask");
    // external source with the pin disabled does not count
    wr(`TPC_IDX_TCR, 8'h20);
    ext_count("gated count", 8'h05, 3, 8'h05);
    check("pin disabled", 8'h00, {7'h00, ext_pin_enable});
    wr(`TPC_IDX_TCR, 8'h30);
    ext_count("event count", 8'h04, 3, 8'h01);
    end_test("external source");
    // no high voltage: enables disconnected, nothing programmed
    wr(`TPC_IDX_PAL, 8'h38);
    wr(`TPC_IDX_PAH, 8'h0F);
    wr(`TPC_IDX_PDT, 8'h60);
    wr(`TPC_IDX_PCR, 8'h00);
    rd_chk("pcr without vpp", `TPC_IDX_PCR, 8'hFC);
    wr(`TPC_IDX_PCR, 8'h03);
    rd_chk("not programmed", `TPC_IDX_OPT, 8'h00);
    // latch with high voltage, then program one byte
    vpp_high <= 1'b1;
    idle(4);
    wr(`TPC_IDX_PCR, 8'h02);
    rd_chk("pcr latching", `TPC_IDX_PCR, 8'hFA);
    wr(`TPC_IDX_PCR, 8'h00);
    wr(`TPC_IDX_PCR, 8'h03);
    vpp_high <= 1'b0;
    idle(4);
    rd_chk("programmed", `TPC_IDX_OPT, 8'h60);
    // a write with lane zero off is acked but ignored
    wb_sel_i <= 4'h0;
    wr(`TPC_IDX_PAL, 8'h55);
    wb_sel_i <= 4'h1;
    rd_chk("lane ignored", `TPC_IDX_PAL, 8'h38);
    end_test("programming");
    // option mode: timer option and external source, divide by one
    do_reset();
    rd_chk("option kept", `TPC_IDX_OPT, 8'h60);
    rd_chk("option control", `TPC_IDX_TCR, 8'h3F);
    check("option pin enable", 8'h01, {7'h00, ext_pin_enable});
    wr(`TPC_IDX_TCR, 8'h40);
    rd_chk("option write", `TPC_IDX_TCR, 8'h7F);
    ext_count("option events", 8'h04, 3, 8'h01);
    end_test("option mode");
    report_and_stop();
  end
endmodule

// File: rtl/tpc_nvm.sv
// small nonvolatile byte array holding the option byte window
`include "tpc_regs.svh"
module tpc_nvm #(
  parameter int DEPTH = 16,
  parameter int AW = 4
) (
  // clock and reset
  clk_sys,
  rstn,
  // bus read port
  rd_addr,
  rd_data,
  // programming port
  wr_en,
  wr_addr,
  wr_data,
  // option byte tap
  opt_data
);
  import tpc_pkg::*;
  input wire logic clk_sys;
  input wire logic rstn;
  input wire logic [AW-1:0] rd_addr;
  output logic [7:0] rd_data;
  input wire logic wr_en;
  input wire logic [AW-1:0] wr_addr;
  input wire logic [7:0] wr_data;
  output tpc_pkg::tpc_nvm_rd_t opt_data;

  // cells survive reset; an unprogrammed cell reads zero
  logic [7:0] cells [DEPTH];
  tpc_nvm_rd_t r_ff, nxt_r;

  // erased state
  initial begin
    for (int i = 0; i < DEPTH; i++) begin
      cells[i] = 8'h00;
    end
  end

  // programming can only add ones, like a real cell
  always_ff @(posedge clk_sys) begin
    if (wr_en) begin
      cells[wr_addr] <= cells[wr_addr] | wr_data;
    end
  end

  // next read values
  always_comb begin
    nxt_r.rd = cells[rd_addr];
    nxt_r.opt = cells[`TPC_OPT_SLOT];
  end

  // read registers
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      r_ff <= '0;
    end else begin
      r_ff <= nxt_r;
    end
  end

  assign rd_data = r_ff.rd;
  assign opt_data = r_ff;
endmodule

// File: rtl/tpc_pkg.sv
// types shared by the timer control block
package tpc_pkg;

  // startup phases: wait for option byte, load it, run
  typedef enum logic [1:0] {TPC_LOAD0, TPC_LOAD1, TPC_RUN} tpc_phase_t;

  // whole state of the control block
  typedef struct packed {
    tpc_phase_t phase;
    logic tin_s1;
    logic tin_s2;
    logic tin_prev;
    logic vpp_s1;
    logic vpp_s2;
    logic [1:0] div_cnt;
    logic timer_option_select;
    logic interrupt_request_flag;
    logic tim;
    logic input_source_select;
    logic external_pin_enable;
    logic [2:0] ps;
    logic [6:0] psc_cnt;
    logic [7:0] count;
    logic ple_n;
    logic pge_n;
    logic [11:0] paddr;
    logic [7:0] pdata;
    logic [11:0] laddr;
    logic [7:0] ldata;
    logic prog_prev;
    logic pend;
    logic ack;
    logic [7:0] rdat;
    logic irq;
    logic pin_en;
  } tpc_state_t;

  // registered read ports of the nonvolatile array
  typedef struct packed {
    logic [7:0] rd;
    logic [7:0] opt;
  } tpc_nvm_rd_t;

endpackage

// File: rtl/tpc_regs.svh
// register indices, field positions, reset values and timing counts
`ifndef TPC_REGS_SVH
`define TPC_REGS_SVH

// register indices, byte address is four times the index
`define TPC_IDX_TDR 12'h008
`define TPC_IDX_TCR 12'h009
`define TPC_IDX_PCR 12'h00B
`define TPC_IDX_PAL 12'h00C
`define TPC_IDX_PAH 12'h00D
`define TPC_IDX_PDT 12'h00E
`define TPC_IDX_OPT 12'hF38
// nonvolatile window F30..F3F, upper index bits
`define TPC_NVM_HI 8'hF3
`define TPC_OPT_SLOT 4'h8

// timer control fields
`define TPC_B_TIR 7
`define TPC_B_TIM 6
`define TPC_B_TIN 5
`define TPC_B_TIE 4
`define TPC_B_PSC 3
`define TPC_PS_HI 2
// option byte fields
`define TPC_B_TIMER_OPTION_SELECT 6
`define TPC_B_CLS 5
`define TPC_B_OTIE 4
// programming control fields
`define TPC_B_HIGH_VOLTAGE_STATUS 2
`define TPC_B_PGE 1
`define TPC_B_PLE 0
`define TPC_PCR_ONES 5'h1F
`define TPC_OPT_ONES 6'h3F

// internal clock is the system clock divided by four
`define TPC_FOSC_DIV 4
`define TPC_DIV_LAST 2'((`TPC_FOSC_DIV) - 1)
`define TPC_CNT_ONE 8'h01
`define TPC_CNT_RST 8'hFF
`define TPC_EXT_DIV 8

`endif

// File: rtl/tpc_timer_ctl.sv
// timer prescaler, option byte and programming control with wishbone slave
// What this block does
// - both enables one: count external pin edges
// - option mode: bits 0,1,2,5 from option byte
// - option mode: bits 4 and 3 held one
// - timer control at 009, bit 3 special
// - option bits loaded at reset, read one
// - zero reached sets flag; reset, write-zero clear
// - mask bit one blocks timer interrupt
// - select external or system clock over four
// - enable bit gates pin, option mode one
// - clear bit zeroes prescaler, reads zero
// - select code n divides by two power n
// - option byte at F38, nonvolatile, erased zero
// - software mode: option bits give initial values
// - option bit 5 chooses clock source
// - option divide bits use same table
// - programming control at 00B, upper ones
// - latch enable low latches address, data
// - program only with both enables low
// - no high voltage disconnects both enables
// - program only when all three zero
// - counter decrements per tap, wraps round
`include "tpc_regs.svh"
module tpc_timer_ctl (
  // system
  input wire logic clk_sys,
  input wire logic rstn,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [13:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // pins
  input wire logic timer_pin,
  input wire logic vpp_high,
  // to the processor and pad
  output logic ext_pin_enable,
  output logic timer_irq
);
  import tpc_pkg::*;

  tpc_state_t s_ff, nxt_s;
  tpc_nvm_rd_t nvm_opt;
  logic [7:0] nvm_rd;
  logic [11:0] idx;
  logic [7:0] wd;
  logic req;
  logic wr;
  logic int_tick;
  logic ext_edge;
  logic src_tick;
  logic psc_tick;
  logic high_voltage_status;
  logic prog_now;
  logic nvm_we;

  // mask of prescaler bits that must be all ones for a tap
  function automatic logic [6:0] psc_mask(input logic [2:0] n);
    psc_mask = 7'((8'h01 << n) - 8'h01);
  endfunction

  // index falls inside the nonvolatile window
  function automatic logic in_nvm(input logic [11:0] a);
    in_nvm = (a[11:4] == `TPC_NVM_HI);
  endfunction

  // bus request decode
  assign idx = wb_adr_i[13:2];
  assign wd = wb_dat_i[7:0];
  assign req = wb_cyc_i & wb_stb_i & ~s_ff.pend & ~s_ff.ack & (s_ff.phase == TPC_RUN);
  assign wr = s_ff.pend & wb_we_i & wb_sel_i[0];

  // internal clock tick, system clock over four
  assign int_tick = (s_ff.div_cnt == `TPC_DIV_LAST);
  // rising edge of the synchronised pin
  assign ext_edge = s_ff.tin_s2 & ~s_ff.tin_prev;

  // source selection; option mode forces the enable high
  always_comb begin
    case ({s_ff.timer_option_select | s_ff.external_pin_enable, s_ff.input_source_select})
      2'b11: src_tick = ext_edge; // external events
      2'b10: src_tick = int_tick & s_ff.tin_s2; // gated internal clock
      2'b00: src_tick = int_tick; // internal clock
      default: src_tick = 1'b0; // disabled
    endcase
  end

  // prescaler tap at divide by two power n
  assign psc_tick = src_tick & ((s_ff.psc_cnt & psc_mask(s_ff.ps)) == psc_mask(s_ff.ps));

  // interlock: status reads one when no high voltage
  assign high_voltage_status = ~s_ff.vpp_s2;
  // programming condition
  assign prog_now = ~high_voltage_status & ~s_ff.pge_n & ~s_ff.ple_n;
  // one program pulse per entry into the condition
  assign nvm_we = prog_now & ~s_ff.prog_prev & in_nvm(s_ff.laddr);

  // next state
  always_comb begin
    logic [7:0] rmux;
    rmux = 8'h00;
    nxt_s = s_ff;

    // two flop synchronisers, edge seen on second stage
    nxt_s.tin_s1 = timer_pin;
    nxt_s.tin_s2 = s_ff.tin_s1;
    nxt_s.tin_prev = s_ff.tin_s2;
    nxt_s.vpp_s1 = vpp_high;
    nxt_s.vpp_s2 = s_ff.vpp_s1;

    // divider for the internal clock
    if (int_tick) begin
      nxt_s.div_cnt = 2'h0;
    end else begin
      nxt_s.div_cnt = s_ff.div_cnt + 2'h1;
    end

    // startup: option byte read port settles, then load
    case (s_ff.phase)
      TPC_LOAD0: begin
        nxt_s.phase = TPC_LOAD1;
      end
      TPC_LOAD1: begin
        // load source, enable and divide from option byte
        nxt_s.timer_option_select = nvm_opt.opt[`TPC_B_TIMER_OPTION_SELECT];
        nxt_s.input_source_select = nvm_opt.opt[`TPC_B_CLS];
        nxt_s.external_pin_enable = nvm_opt.opt[`TPC_B_OTIE];
        nxt_s.ps = nvm_opt.opt[`TPC_PS_HI:0];
        nxt_s.phase = TPC_RUN;
      end
      TPC_RUN: begin
        nxt_s.phase = TPC_RUN;
      end
      default: begin
        nxt_s.phase = TPC_LOAD0;
      end
    endcase

    // prescaler counts source ticks
    if (src_tick) begin
      nxt_s.psc_cnt = s_ff.psc_cnt + 7'h01;
    end
    // counter steps down, wrapping from zero to all ones
    if (psc_tick) begin
      nxt_s.count = s_ff.count - 8'h01;
    end

    // read data mux
    case (idx)
      `TPC_IDX_TDR: rmux = s_ff.count;
      `TPC_IDX_TCR: begin
        if (s_ff.timer_option_select) begin
          rmux = {s_ff.interrupt_request_flag, s_ff.tim, `TPC_OPT_ONES};
        end else begin
          rmux = {s_ff.interrupt_request_flag, s_ff.tim, s_ff.input_source_select, s_ff.external_pin_enable, 1'b0, s_ff.ps};
        end
      end
      `TPC_IDX_PCR: rmux = {`TPC_PCR_ONES, high_voltage_status, s_ff.pge_n, s_ff.ple_n};
      `TPC_IDX_PAL: rmux = s_ff.paddr[7:0];
      `TPC_IDX_PAH: rmux = {4'h0, s_ff.paddr[11:8]};
      `TPC_IDX_PDT: rmux = s_ff.pdata;
      default: begin
        // nonvolatile window, option byte included
        if (in_nvm(idx)) begin
          rmux = nvm_rd;
        end
      end
    endcase

    // bus handshake: accept, one wait cycle, then ack
    nxt_s.pend = req;
    nxt_s.ack = s_ff.pend;
    if (s_ff.pend) begin
      nxt_s.rdat = rmux;
    end

    // register writes
    if (wr) begin
      case (idx)
        `TPC_IDX_TDR: nxt_s.count = wd;
        `TPC_IDX_TCR: begin
          // flag only clears by writing zero
          if (!wd[`TPC_B_TIR]) begin
            nxt_s.interrupt_request_flag = 1'b0;
          end
          nxt_s.tim = wd[`TPC_B_TIM];
          // option mode keeps the loaded bits
          if (!s_ff.timer_option_select) begin
            nxt_s.input_source_select = wd[`TPC_B_TIN];
            nxt_s.external_pin_enable = wd[`TPC_B_TIE];
            nxt_s.ps = wd[`TPC_PS_HI:0];
            // clear in the same write as a new select
            if (wd[`TPC_B_PSC]) begin
              nxt_s.psc_cnt = 7'h00;
            end
          end
        end
        `TPC_IDX_PCR: begin
          nxt_s.pge_n = wd[`TPC_B_PGE];
          nxt_s.ple_n = wd[`TPC_B_PLE];
        end
        `TPC_IDX_PAL: nxt_s.paddr[7:0] = wd;
        `TPC_IDX_PAH: nxt_s.paddr[11:8] = wd[3:0];
        `TPC_IDX_PDT: nxt_s.pdata = wd;
        default: begin
          // read only or unmapped: ignored
        end
      endcase
    end

    // reaching zero sets the flag; set wins over clear
    if (psc_tick && s_ff.count == `TPC_CNT_ONE) begin
      nxt_s.interrupt_request_flag = 1'b1;
    end

    // latch address and data while latch enable is low
    if (!high_voltage_status && !s_ff.ple_n) begin
      nxt_s.laddr = s_ff.paddr;
      nxt_s.ldata = s_ff.pdata;
    end
    nxt_s.prog_prev = prog_now;

    // outputs
    nxt_s.irq = s_ff.interrupt_request_flag & ~s_ff.tim;
    nxt_s.pin_en = s_ff.timer_option_select | s_ff.external_pin_enable;
  end

  // state register; enables of the programming path start high
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      s_ff <= '0;
      s_ff.ple_n <= 1'b1;
      s_ff.pge_n <= 1'b1;
      s_ff.count <= `TPC_CNT_RST;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // nonvolatile array and option byte
  tpc_nvm #(
    .DEPTH(16),
    .AW(4)
  ) u_nvm (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .rd_addr(wb_adr_i[5:2]),
    .rd_data(nvm_rd),
    .wr_en(nvm_we),
    .wr_addr(s_ff.laddr[3:0]),
    .wr_data(s_ff.ldata),
    .opt_data(nvm_opt)
  );

  // outputs straight from flops
  assign wb_dat_o = {24'h0000_00, s_ff.rdat};
  assign wb_ack_o = s_ff.ack;
  assign timer_irq = s_ff.irq;
  assign ext_pin_enable = s_ff.pin_en;

  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  sequence seq_req;
    req;
  endsequence
  sequence seq_int_period;
    int_tick ##1 !int_tick [*3] ##1 int_tick;
  endsequence

  a_ack_latency: assert property (seq_req |-> ##2 wb_ack_o)
    else $error("ack not two cycles after request");
  a_int_divide: assert property (int_tick |-> seq_int_period)
    else $error("internal tick not every fourth cycle");
  a_flag_set: assert property (psc_tick && s_ff.count == `TPC_CNT_ONE |=> s_ff.interrupt_request_flag)
    else $error("flag not set at zero");
  a_irq_mask: assert property (s_ff.tim |=> !timer_irq)
    else $error("masked interrupt reached output");
  a_irq_follow: assert property (s_ff.interrupt_request_flag && !s_ff.tim |=> timer_irq)
    else $error("unmasked flag not on interrupt");
  a_psc_clear: assert property (wr && idx == `TPC_IDX_TCR && wd[`TPC_B_PSC] && !s_ff.timer_option_select
    |=> s_ff.psc_cnt == 7'h00)
    else $error("prescaler not cleared");
  a_opt_ones: assert property (s_ff.pend && !wb_we_i && idx == `TPC_IDX_TCR && s_ff.timer_option_select
    |=> wb_dat_o[5:0] == `TPC_OPT_ONES)
    else $error("option mode bits not reading one");
  a_pcr_upper: assert property (s_ff.pend && !wb_we_i && idx == `TPC_IDX_PCR
    |=> wb_dat_o[7:3] == `TPC_PCR_ONES)
    else $error("programming control upper bits not one");
  a_prog_gate: assert property (nvm_we |-> !high_voltage_status && !s_ff.pge_n && !s_ff.ple_n)
    else $error("programming without all enables low");
  a_pin_forced: assert property (s_ff.timer_option_select |=> ext_pin_enable)
    else $error("pin enable low in option mode");
  a_count_wrap: assert property (psc_tick && !wr |=> s_ff.count == $past(s_ff.count) - 8'h01)
    else $error("counter did not step down");

  // the counter moves only on a tap or a load through the bus
  a_count_hold: assert property (!psc_tick && !(wr && idx == `TPC_IDX_TDR) |=> s_ff.count == $past(s_ff.count))
    else $error("counter moved without a tap");
  // a tap can only come from a source tick
  a_tap_gate: assert property (psc_tick |-> src_tick)
    else $error("prescaler tap without a source tick");
  // source enabled but pin disabled gives no ticks at all
  a_src_off: assert property (s_ff.input_source_select && !s_ff.external_pin_enable && !s_ff.timer_option_select |-> !src_tick)
    else $error("disabled source still ticking");
  // the flag stays set until software writes the control register
  a_flag_hold: assert property (s_ff.interrupt_request_flag && !(wr && idx == `TPC_IDX_TCR) |=> s_ff.interrupt_request_flag)
    else $error("flag dropped without a write");
  // the startup load takes source select from the option byte
  a_opt_load: assert property (s_ff.phase == TPC_LOAD1 |=> s_ff.input_source_select == $past(nvm_opt.opt[`TPC_B_CLS]))
    else $error("source select not loaded from option byte");
  // option mode ignores software writes to the divide select
  a_opt_keep: assert property (s_ff.timer_option_select && wr && idx == `TPC_IDX_TCR |=> s_ff.ps == $past(s_ff.ps))
    else $error("divide select changed in option mode");
  // the clear bit reads zero in software mode
  a_clr_read: assert property (s_ff.pend && !wb_we_i && idx == `TPC_IDX_TCR && !s_ff.timer_option_select
    |=> !wb_dat_o[`TPC_B_PSC])
    else $error("prescaler clear bit not reading zero");
  // software mode pin enable follows the enable bit
  a_pin_follow: assert property (!s_ff.timer_option_select |=> ext_pin_enable == $past(s_ff.external_pin_enable))
    else $error("pin enable not following enable bit");
  // address copied into the array latch while latch enable is low
  a_latch_copy: assert property (!high_voltage_status && !s_ff.ple_n |=> s_ff.laddr == $past(s_ff.paddr))
    else $error("address not latched");
  // without high voltage nothing is ever programmed
  a_vpp_block: assert property (high_voltage_status |-> !nvm_we)
    else $error("programming without high voltage");
  // acknowledge lasts exactly one cycle
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
endmodule
